// ==== srff_frame_fifo.sv ====
// Sensor result frame buffer: 512-byte frame store with register readout.
// Assumes the sensor core strobes results, mode and config-change events on clk_sys.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module srff_frame_fifo
	import srff_pkg::*;
#(
	parameter int DEPTH = SRFF_DEPTH
)(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire srff_bus_s   bus,
	output logic      [7:0]  rdata,
	input  wire srff_meas_s  meas,
	input  wire logic        normal_mode,
	input  wire logic        cfg_error,
	input  wire logic        cfg_changed,
	input  wire logic [23:0] timestamp_counter,
	input  wire logic        burst_active,
	output logic      [7:0]  burst_next_addr
);

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	logic [7:0] mem [DEPTH];
	logic [8:0] wr_ptr_r, rd_ptr_r, frm_ptr_r, frm_base_r;
	logic [9:0] count_r;
	logic [4:0] cfg_one_r;
	logic [4:0] cfg_two_r;
	logic [6:0] dec_cnt_r;
	logic       normal_d_r, chg_pend_r, err_pend_r, first_r;
	logic [3:0] wr_left_r;
	logic [3:0] wr_len_r;
	logic       meas_pend_r;
	logic [23:0] pend_t_r, pend_p_r;
	logic [7:0] wr_buf_r [SRFF_MAX_FRAME];
	srff_rd_e   rd_st_r;
	logic [3:0] rd_left_r;
	logic [7:0] rdata_r;
	logic [23:0] ts_cap_r;
	logic [1:0] ts_idx_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic collect_on  = cfg_one_r[SRFF_C1_COLLECT];
	wire logic halt_sat    = cfg_one_r[SRFF_C1_HALT];
	wire logic time_on     = cfg_one_r[SRFF_C1_TIME];
	wire logic store_p     = cfg_one_r[SRFF_C1_PRESS];
	wire logic store_t     = cfg_one_r[SRFF_C1_TEMP];
	wire logic [2:0] dec_exp = cfg_two_r[SRFF_C2_DEC_LSB +: 3];
	wire logic [1:0] src_sel = cfg_two_r[SRFF_C2_SRC_LSB +: 2];
	wire logic write_en    = collect_on && (store_p || store_t);
	wire logic use_filt    = (src_sel == SRFF_SRC_FILTERED);
	wire logic [6:0] dec_mask = 7'((8'h01 << dec_exp) - 8'h01);
	wire logic sleep_wake  = normal_mode && !normal_d_r;
	wire logic dec_hit     = !normal_mode || first_r ||
	                         ((dec_cnt_r & dec_mask) == 7'h00);
	wire logic [23:0] t_val = use_filt ? meas.temp_filt  : meas.temp_raw;
	wire logic [23:0] p_val = use_filt ? meas.press_filt : meas.press_raw;
	wire logic [23:0] t_src = meas_pend_r ? pend_t_r : t_val;
	wire logic [23:0] p_src = meas_pend_r ? pend_p_r : p_val;
	wire logic [3:0] meas_len = 4'(1 + (store_t ? 3 : 0) + (store_p ? 3 : 0));
	wire logic [7:0] meas_hdr = {SRFF_KIND_SENSOR, 1'b0, store_t, 1'b0, store_p, 2'b00};
	wire logic take_meas   = meas.valid && write_en && dec_hit && wr_left_r == 4'h0;
	wire logic cmd_wr      = bus.wr && bus.addr == SRFF_ADDR_CMD;
	wire logic flush       = cmd_wr && (bus.wdata == SRFF_CMD_FLUSH ||
	                                   bus.wdata == SRFF_CMD_SOFTRST);
	wire logic port_rd     = bus.rd && bus.addr == SRFF_ADDR_READ_PORT;

	// Frame length from a stored header
	function automatic logic [3:0] srff_len(input logic [7:0] hdr);
		if (hdr[7:6] == SRFF_KIND_CONTROL)
			srff_len = 4'h2;
		else
			srff_len = 4'(1 + (hdr[4] ? 3 : 0) + (hdr[2] ? 3 : 0));
	endfunction : srff_len

	// ----------------------------------------------------------------
	// Write side: assemble then commit a whole frame
	// ----------------------------------------------------------------
	wire logic [3:0] old_len   = srff_len(mem[frm_base_r]);
	wire logic [9:0] free_sp   = 10'(DEPTH) - count_r;
	wire logic       is_full   = free_sp < 10'(SRFF_MAX_FRAME);
	wire logic       fits      = free_sp >= 10'(wr_len_r);
	wire logic       committing = wr_left_r != 4'h0 && (halt_sat ? !is_full : fits);
	wire logic       evict     = wr_left_r != 4'h0 && !fits && !halt_sat
	                             && count_r != 10'h000;
	wire logic       drop_new  = wr_left_r != 4'h0 && is_full && halt_sat;
	wire logic [3:0] rd_frm_len = srff_len(mem[frm_ptr_r]);
	wire logic       frm_done  = port_rd && burst_active && !flush && rd_st_r == SRFF_RD_DATA
	                             && rd_left_r == 4'h2;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfg_one_r  <= '0;
			cfg_two_r  <= '0;
			normal_d_r <= 1'b0;
			first_r    <= 1'b0;
			dec_cnt_r  <= '0;
			chg_pend_r <= 1'b0;
			err_pend_r <= 1'b0;
			wr_left_r  <= '0;
			wr_len_r   <= '0;
			meas_pend_r <= 1'b0;
			pend_t_r   <= '0;
			pend_p_r   <= '0;
		end
		else
		begin
			normal_d_r <= normal_mode;
			if (bus.wr && bus.addr == SRFF_ADDR_CFG_ONE)
				cfg_one_r <= bus.wdata[4:0];
			if (bus.wr && bus.addr == SRFF_ADDR_CFG_TWO)
				cfg_two_r <= bus.wdata[4:0];
			if (sleep_wake)
			begin
				first_r   <= 1'b1;
				dec_cnt_r <= '0;
			end
			else if (meas.valid && normal_mode)
			begin
				first_r   <= 1'b0;
				dec_cnt_r <= 7'(dec_cnt_r + 7'h01);
			end
			if (cfg_changed && normal_mode && write_en)
				chg_pend_r <= 1'b1;
			if (cfg_error)
				err_pend_r <= 1'b1;
			if (wr_left_r == 4'h0 && err_pend_r && write_en)
			begin
				wr_buf_r[0] <= {SRFF_KIND_CONTROL, SRFF_PARAM_CFGERR, 2'b00};
				wr_buf_r[1] <= SRFF_OPCODE_ERR;
				wr_len_r    <= 4'h2;
				wr_left_r   <= 4'h2;
				err_pend_r  <= cfg_error;
			end
			else if (take_meas && chg_pend_r)
			begin
				wr_buf_r[0] <= {SRFF_KIND_CONTROL, SRFF_PARAM_CFGCHG, 2'b00};
				wr_buf_r[1] <= SRFF_OPCODE_CHG;
				wr_len_r    <= 4'h2;
				wr_left_r   <= 4'h2;
				chg_pend_r  <= 1'b0;
				meas_pend_r <= 1'b1;
				pend_t_r    <= t_val;
				pend_p_r    <= p_val;
			end
			else if (take_meas || (meas_pend_r && write_en && wr_left_r == 4'h0))
			begin
				wr_buf_r[0] <= meas_hdr;
				wr_buf_r[1] <= store_t ? t_src[7:0]   : p_src[7:0];
				wr_buf_r[2] <= store_t ? t_src[15:8]  : p_src[15:8];
				wr_buf_r[3] <= store_t ? t_src[23:16] : p_src[23:16];
				wr_buf_r[4] <= p_src[7:0];
				wr_buf_r[5] <= p_src[15:8];
				wr_buf_r[6] <= p_src[23:16];
				wr_len_r    <= meas_len;
				wr_left_r   <= meas_len;
				meas_pend_r <= 1'b0;
			end
			else if (committing || drop_new || flush)
				wr_left_r <= '0;
		end
	end

	// Byte copy into the array; frame becomes visible once all bytes are in
	always_ff @(posedge clk_sys)
	begin
		if (committing)
			for (int i = 0; i < SRFF_MAX_FRAME - 2; i++)
				if (4'(i) < wr_len_r)
					mem[9'(wr_ptr_r + 9'(i))] <= wr_buf_r[i];
	end

	// ----------------------------------------------------------------
	// Pointers and visible count
	// ----------------------------------------------------------------
	wire logic [9:0] add_len = committing ? 10'(wr_len_r) : 10'h000;
	wire logic [9:0] sub_len = evict ? 10'(old_len) :
	                           (frm_done ? 10'(rd_frm_len) : 10'h000);

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_r   <= '0;
			frm_base_r <= '0;
			count_r    <= '0;
		end
		else if (flush)
		begin
			wr_ptr_r   <= '0;
			frm_base_r <= '0;
			count_r    <= '0;
		end
		else
		begin
			if (committing)
				wr_ptr_r <= 9'(wr_ptr_r + 9'(wr_len_r));
			if (evict)
				frm_base_r <= 9'(frm_base_r + 9'(old_len));
			else if (frm_done)
				frm_base_r <= 9'(frm_base_r + 9'(rd_frm_len));
			count_r <= count_r + add_len - sub_len;
		end
	end

	// ----------------------------------------------------------------
	// Read side
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_st_r   <= SRFF_RD_IDLE;
			rd_left_r <= '0;
			rd_ptr_r  <= '0;
			frm_ptr_r <= '0;
			ts_cap_r  <= '0;
			ts_idx_r  <= '0;
			rdata_r   <= '0;
		end
		else if (!burst_active || flush)
		begin
			rd_st_r <= SRFF_RD_IDLE;
			rdata_r <= '0;
		end
		else if (port_rd)
		begin
			case (rd_st_r)
				SRFF_RD_IDLE, SRFF_RD_DATA:
				begin
					if (rd_st_r == SRFF_RD_DATA && rd_left_r > 4'h1)
					begin
						rdata_r   <= mem[rd_ptr_r];
						rd_ptr_r  <= 9'(rd_ptr_r + 9'h001);
						rd_left_r <= rd_left_r - 4'h1;
						rd_st_r   <= SRFF_RD_DATA;
					end
					else if (count_r != 10'h000)
					begin
						// Start next frame from the oldest valid one
						rdata_r   <= mem[frm_base_r];
						frm_ptr_r <= frm_base_r;
						rd_ptr_r  <= 9'(frm_base_r + 9'h001);
						rd_left_r <= srff_len(mem[frm_base_r]);
						rd_st_r   <= SRFF_RD_DATA;
					end
					else if (time_on)
					begin
						rdata_r   <= {SRFF_KIND_SENSOR, SRFF_PARAM_TIME, 2'b00};
						ts_cap_r  <= timestamp_counter;
						ts_idx_r  <= '0;
						rd_st_r   <= SRFF_RD_TIME;
					end
					else
					begin
						rdata_r   <= SRFF_HDR_EMPTY;
						rd_left_r <= 4'h1;
						rd_st_r   <= SRFF_RD_EMPTY;
					end
				end
				SRFF_RD_TIME:
				begin
					rdata_r  <= ts_cap_r[8*ts_idx_r +: 8];
					ts_idx_r <= 2'(ts_idx_r + 2'h1);
					if (ts_idx_r == 2'h2)
					begin
						rd_st_r   <= SRFF_RD_EMPTY;
						rd_left_r <= '0;
					end
				end
				SRFF_RD_EMPTY:
				begin
					rdata_r   <= rd_left_r != 4'h0 ? 8'h00 : SRFF_HDR_EMPTY;
					rd_left_r <= rd_left_r != 4'h0 ? 4'h0 : 4'h1;
				end
				default:
					rd_st_r <= SRFF_RD_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	logic [7:0] reg_r;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			reg_r <= '0;
		else if (bus.rd)
		begin
			case (bus.addr)
				SRFF_ADDR_FILL_LOW:  reg_r <= count_r[7:0];
				SRFF_ADDR_FILL_HIGH: reg_r <= {7'h00, count_r[8]};
				SRFF_ADDR_CFG_ONE:   reg_r <= {3'h0, cfg_one_r};
				SRFF_ADDR_CFG_TWO:   reg_r <= {3'h0, cfg_two_r};
				default:             reg_r <= '0;
			endcase
		end
	end

	logic rd_port_d_r;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rd_port_d_r <= 1'b0;
		else
			rd_port_d_r <= port_rd;
	end

	assign rdata = rd_port_d_r ? rdata_r : reg_r;
	assign burst_next_addr = (bus.addr == SRFF_ADDR_READ_PORT) ? bus.addr
	                         : 8'(bus.addr + 8'h01);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_count_max: assert property (@(posedge clk_sys) disable iff (!reset_n)
		count_r <= 10'(DEPTH)) else $error("count above depth");
	chk_full_no_grow: assert property (@(posedge clk_sys) disable iff (!reset_n)
		halt_sat && !fits && wr_left_r != 4'h0 |=> count_r <= $past(count_r))
		else $error("count grew while halted full");
	chk_count_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!flush && !committing && !evict && !frm_done |=> $stable(count_r))
		else $error("count moved without a frame");
	chk_disabled_noin: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!write_en && wr_left_r == 4'h0 && !chg_pend_r |=> wr_left_r == 4'h0
		|| $past(err_pend_r)) else $error("frame started while disabled");
	chk_flush_empty: assert property (@(posedge clk_sys) disable iff (!reset_n)
		flush |=> count_r == 10'h000) else $error("flush left data");
	chk_fill_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.rd && bus.addr == SRFF_ADDR_FILL_HIGH ##1 !rd_port_d_r
		|-> rdata[7:1] == 7'h00) else $error("fill high upper bits set");
	chk_burst_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.addr == SRFF_ADDR_READ_PORT |-> burst_next_addr == SRFF_ADDR_READ_PORT)
		else $error("burst left read port");
	chk_empty_hdr: assert property (@(posedge clk_sys) disable iff (!reset_n)
		port_rd && burst_active && !flush && rd_st_r == SRFF_RD_IDLE && count_r == 10'h000
		&& !time_on |=> rdata_r == SRFF_HDR_EMPTY) else $error("empty header wrong");
	chk_full_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		count_r > SRFF_FULL_LEVEL |-> is_full) else $error("full flag wrong");

endmodule : srff_frame_fifo

// ==== srff_host_model.sv ====
// Host model: drives the register port of the frame buffer with write and read cycles.
// Assumes one clock, requests only after reset release, read data one cycle after the strobe.
`timescale 1ns/1ps

module srff_host_model
	import srff_pkg::*;
(
	input  wire logic       clk_sys,
	output srff_bus_s       bus,
	input  wire logic [7:0] rdata
);

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	initial bus = '0;

	// Command writes such as the flush code go through this cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask : wr

	// Read data taken in the cycle after the strobe, never waited for
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

endmodule : srff_host_model

// ==== srff_pkg.sv ====
// Package for the sensor result frame buffer: register map, frame layout, sizes.
// Assumes one clock domain and the plain register port of the top module.
package srff_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SRFF_ADDR_FILL_LOW    = 8'h12;
	localparam logic [7:0] SRFF_ADDR_FILL_HIGH   = 8'h13;
	localparam logic [7:0] SRFF_ADDR_READ_PORT   = 8'h14;
	localparam logic [7:0] SRFF_ADDR_CFG_ONE     = 8'h17;
	localparam logic [7:0] SRFF_ADDR_CFG_TWO     = 8'h18;
	localparam logic [7:0] SRFF_ADDR_CMD         = 8'h7e;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int SRFF_C1_COLLECT = 0;
	localparam int SRFF_C1_HALT    = 1;
	localparam int SRFF_C1_TIME    = 2;
	localparam int SRFF_C1_PRESS   = 3;
	localparam int SRFF_C1_TEMP    = 4;
	localparam int SRFF_C2_DEC_LSB = 0;
	localparam int SRFF_C2_SRC_LSB = 3;
	localparam logic [2:0] SRFF_CFG_ONE_MASK = 3'h7;
	localparam logic [1:0] SRFF_SRC_FILTERED = 2'h1;
	localparam logic [7:0] SRFF_CMD_FLUSH    = 8'hb0;
	localparam logic [7:0] SRFF_CMD_SOFTRST  = 8'hb6;

	localparam logic [1:0] SRFF_KIND_SENSOR  = 2'h2;
	localparam logic [1:0] SRFF_KIND_CONTROL = 2'h1;
	localparam logic [3:0] SRFF_PARAM_CFGERR = 4'h1;
	localparam logic [3:0] SRFF_PARAM_CFGCHG = 4'h2;
	localparam logic [3:0] SRFF_PARAM_TIME   = 4'h8;
	localparam logic [7:0] SRFF_OPCODE_ERR   = 8'h01;
	localparam logic [7:0] SRFF_OPCODE_CHG   = 8'h02;
	localparam logic [7:0] SRFF_HDR_EMPTY    = 8'h80;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int SRFF_DEPTH     = 512;
	localparam int SRFF_MAX_FRAME = 9;
	localparam logic [9:0] SRFF_FULL_LEVEL = 10'(SRFF_DEPTH - SRFF_MAX_FRAME);

	typedef enum { SRFF_RD_IDLE, SRFF_RD_DATA, SRFF_RD_TIME, SRFF_RD_EMPTY } srff_rd_e;

	// Register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} srff_bus_s;

	// Measurement result delivered by the sensor core
	typedef struct packed {
		logic        valid;
		logic [23:0] temp_raw;
		logic [23:0] temp_filt;
		logic [23:0] press_raw;
		logic [23:0] press_filt;
	} srff_meas_s;

endpackage : srff_pkg

// ==== srff_tb.sv ====
// Testbench for the frame buffer: frames stored, read back and counted.
// Assumes the host model for register cycles and a 250 MHz clock.
`timescale 1ns/1ps

module testbench;
	import srff_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk_sys = 1'b0;
	logic        reset_n;
	srff_bus_s   bus;
	logic [7:0]  rdata;
	srff_meas_s  meas;
	logic        normal_mode;
	logic        cfg_error;
	logic        cfg_changed;
	logic [23:0] ts;
	logic        burst_active;
	logic [7:0]  nxt;
	logic [7:0]  d;
	logic [7:0]  q[$];
	int          n_fail;
	int          check_count;
	int          cycles;

	always #2 clk_sys = ~clk_sys;

	srff_frame_fifo u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.meas(meas), .normal_mode(normal_mode), .cfg_error(cfg_error),
		.cfg_changed(cfg_changed), .timestamp_counter(ts), .burst_active(burst_active),
		.burst_next_addr(nxt));
	srff_host_model u_host (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_byte

	task automatic cmp_count(input logic [9:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		u_host.rd(SRFF_ADDR_FILL_LOW, lo);
		u_host.rd(SRFF_ADDR_FILL_HIGH, hi);
		check_count++;
		if ({hi, lo} !== {6'h00, e})
		begin
			n_fail++;
			$display("MISMATCH fill count expected %h seen %h", e, {hi, lo});
		end
	endtask : cmp_count

	task automatic cfg(input logic [7:0] one, input logic [7:0] two);
		u_host.wr(SRFF_ADDR_CFG_ONE, one);
		u_host.wr(SRFF_ADDR_CFG_TWO, two);
	endtask : cfg

	task automatic put_meas(input logic [7:0] i);
		@(posedge clk_sys);
		meas <= '{1'b1, {16'h1312, i}, {16'h2322, i}, {16'h3332, i}, {16'h4342, i}};
		@(posedge clk_sys);
		meas.valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : put_meas

	task automatic pulse(input bit chg);
		@(posedge clk_sys);
		if (chg)
			cfg_changed <= 1'b1;
		else
			cfg_error <= 1'b1;
		@(posedge clk_sys);
		cfg_changed <= 1'b0;
		cfg_error <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : pulse

	task automatic exp_frame(input logic [7:0] h, input logic [7:0] i, input bit f);
		logic [7:0] o;
		o = f ? 8'h10 : 8'h00;
		q.push_back(h);
		if (h[4])
		begin
			q.push_back(i);
			q.push_back(8'h12 + o);
			q.push_back(8'h13 + o);
		end
		if (h[2])
		begin
			q.push_back(i);
			q.push_back(8'h32 + o);
			q.push_back(8'h33 + o);
		end
	endtask : exp_frame

	task automatic drain(input int n);
		logic [7:0] g;
		burst_active <= 1'b1;
		repeat (n)
		begin
			u_host.rd(SRFF_ADDR_READ_PORT, g);
			cmp_byte("read port byte", q.pop_front(), g);
			cmp_byte("burst address", SRFF_ADDR_READ_PORT, nxt);
		end
		burst_active <= 1'b0;
		@(posedge clk_sys);
	endtask : drain

	// ----------------------------------------------------------------
	// Timeout
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset_n = 1'b0;
		meas = '0;
		normal_mode = 1'b0;
		cfg_error = 1'b0;
		cfg_changed = 1'b0;
		ts = 24'h654321;
		burst_active = 1'b0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		cmp_count(10'h000);
		q = '{8'h80, 8'h00};
		drain(2);
		u_host.rd(8'h20, d);
		cmp_byte("unmapped read", 8'h00, d);
		for (int s = 0; s < 4; s++)
		begin
			cfg(8'h19, {3'h0, s[1:0], 3'h0});
			put_meas(8'(s));
			cmp_count(10'h007);
			exp_frame(8'h94, 8'(s), s == 1);
			drain(7);
		end
		for (int k = 0; k < 2; k++)
		begin
			cfg(k ? 8'h11 : 8'h09, 8'h00);
			put_meas(8'h05);
			cmp_count(10'h004);
			exp_frame(k ? 8'h90 : 8'h84, 8'h05, 1'b0);
			drain(4);
		end
		cfg(8'h19, 8'h00);
		put_meas(8'h06);
		put_meas(8'h07);
		cfg(8'h00, 8'h00);
		put_meas(8'h08);
		cmp_count(10'h00e);
		exp_frame(8'h94, 8'h06, 1'b0);
		drain(7);
		cmp_count(10'h007);
		cfg(8'h01, 8'h00);
		put_meas(8'h09);
		cmp_count(10'h007);
		u_host.wr(SRFF_ADDR_CMD, SRFF_CMD_FLUSH);
		cmp_count(10'h000);
		cfg(8'h1d, 8'h00);
		put_meas(8'h0a);
		cmp_count(10'h007);
		exp_frame(8'h94, 8'h0a, 1'b0);
		drain(3);
		cmp_count(10'h007);
		q.delete();
		exp_frame(8'h94, 8'h0a, 1'b0);
		q = {q, 8'ha0, 8'h21, 8'h43, 8'h65, 8'h80, 8'h00};
		drain(13);
		cmp_count(10'h000);
		cfg(8'h19, 8'h00);
		pulse(1'b0);
		cmp_count(10'h002);
		q = '{8'h44, 8'h01};
		drain(2);
		put_meas(8'h0b);
		u_host.wr(SRFF_ADDR_CMD, SRFF_CMD_SOFTRST);
		cmp_count(10'h000);
		cfg(8'h19, 8'h02);
		normal_mode <= 1'b1;
		for (int i = 20; i < 29; i++)
		begin
			put_meas(8'(i));
			if (i % 4 == 0)
				exp_frame(8'h94, 8'(i), 1'b0);
		end
		cmp_count(10'h015);
		drain(21);
		normal_mode <= 1'b0;
		cfg(8'h19, 8'h00);
		u_host.wr(SRFF_ADDR_CMD, SRFF_CMD_FLUSH);
		normal_mode <= 1'b1;
		pulse(1'b1);
		pulse(1'b1);
		put_meas(8'h1e);
		cmp_count(10'h009);
		q = '{8'h48, 8'h02};
		exp_frame(8'h94, 8'h1e, 1'b0);
		drain(9);
		normal_mode <= 1'b0;
		cfg(8'h1b, 8'h00);
		for (int i = 0; i < 73; i++)
			put_meas(8'(i));
		cmp_count(10'h1f8);
		exp_frame(8'h94, 8'h00, 1'b0);
		drain(7);
		put_meas(8'h63);
		cmp_count(10'h1f8);
		u_host.wr(SRFF_ADDR_CMD, SRFF_CMD_FLUSH);
		cfg(8'h19, 8'h00);
		for (int i = 0; i < 74; i++)
			put_meas(8'(i));
		cmp_count(10'h1ff);
		exp_frame(8'h94, 8'h01, 1'b0);
		drain(7);
		give_verdict();
	end

endmodule : testbench
